// *** rtl/iplr_pkg.sv ***
// package: register map, field layout and level codes for the priority-level bank
`default_nettype none
package iplr_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [3:0]  IDX_DEBUG_UNIT     = 4'h1;
  localparam logic [3:0]  IDX_FLASH_PLL_PINS = 4'h2;
  localparam logic [3:0]  IDX_PORTS_CAN      = 4'h3;
  localparam logic [3:0]  IDX_SPI_PORTS      = 4'h4;
  localparam logic [3:0]  IDX_DECODER_SCI    = 4'h5;
  localparam int          ADDR_W             = 8;
  localparam int          REG_W              = 16;
  localparam int          NUM_REGS           = 5;
  localparam int          NUM_SRC            = 35;
  localparam logic [15:0] REG_RESET          = 16'h0000;
  // writable bit masks; zero bits are reserved
  localparam logic [15:0] MASK_DEBUG_UNIT     = 16'h000f;
  localparam logic [15:0] MASK_FLASH_PLL_PINS = 16'hffcf;
  localparam logic [15:0] MASK_PORTS_CAN      = 16'hfffc;
  localparam logic [15:0] MASK_SPI_PORTS      = 16'hfc3f;
  localparam logic [15:0] MASK_DECODER_SCI    = 16'hff3f;
  // priority field codes
  localparam logic [1:0]  FIELD_OFF  = 2'h0;
  localparam logic [1:0]  FIELD_LVL1 = 2'h1;
  localparam logic [1:0]  FIELD_LVL2 = 2'h2;
  localparam logic [1:0]  FIELD_LVL3 = 2'h3;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // core-level encoding of a decoded field: enable plus level 0..3
  localparam logic [1:0]  LEVEL_0 = 2'h0;
  localparam logic [1:0]  LEVEL_1 = 2'h1;
  localparam logic [1:0]  LEVEL_2 = 2'h2;
  localparam logic [1:0]  LEVEL_3 = 2'h3;
  // bus slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RESP = 3'h2,
    ST_HOLD = 3'h4
  } iplr_state_e;
endpackage
`default_nettype wire

// *** rtl/iplr_decode.sv ***
// iplr_decode: turns one 2-bit priority field into enable and core level
`default_nettype none
module iplr_decode #(
  parameter bit DEBUG_SRC = 1'b0
) (
  // stored field
  input  wire logic [1:0] field,
  // decoded level
  output logic            enable,
  output logic [1:0]      level
);
  // zero code keeps the source disabled
  always_comb begin
    enable = (field != iplr_pkg::FIELD_OFF);
    level  = iplr_pkg::LEVEL_0;
    if (DEBUG_SRC) begin
      case (field)
        iplr_pkg::FIELD_LVL1: level = iplr_pkg::LEVEL_1;
        iplr_pkg::FIELD_LVL2: level = iplr_pkg::LEVEL_2;
        iplr_pkg::FIELD_LVL3: level = iplr_pkg::LEVEL_3;
        default:              level = iplr_pkg::LEVEL_0;
      endcase
    end else begin
      case (field)
        iplr_pkg::FIELD_LVL1: level = iplr_pkg::LEVEL_0;
        iplr_pkg::FIELD_LVL2: level = iplr_pkg::LEVEL_1;
        iplr_pkg::FIELD_LVL3: level = iplr_pkg::LEVEL_2;
        default:              level = iplr_pkg::LEVEL_0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/iplr_axi_slave.sv ***
// iplr_axi_slave: axi4-lite front end giving one-word register accesses
`default_nettype none
module iplr_axi_slave #(
  parameter int ADDR_W = iplr_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // axi write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // register file side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [15:0]            wr_data,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [15:0]       rd_data,
  input  wire logic              rd_ok
);
  logic              aw_held;  // address captured
  logic              w_held;   // data captured
  logic [ADDR_W-1:0] aw_q;
  logic [31:0]       w_q;
  logic [3:0]        strb_q;
  // channel readies while slot empty and no response pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // write fires once both halves are present
  assign wr_en   = aw_held && w_held && !s_axi_bvalid;
  assign wr_addr = aw_q;
  assign wr_data = w_q[15:0];
  assign rd_addr = s_axi_araddr;
  // capture address and data in either order
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= '0;
      w_q     <= '0;
      strb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_q    <= s_axi_wdata;
        strb_q <= s_axi_wstrb;
      end else if (wr_en) begin
        w_held <= 1'b0;
      end
    end
  end
  // write response
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= iplr_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_ok && strb_q[1:0] == 2'h3) ? iplr_pkg::RESP_OKAY : iplr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // read response
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= iplr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_data};
      s_axi_rresp  <= rd_ok ? iplr_pkg::RESP_OKAY : iplr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/iplr_top.sv ***
// iplr_top: priority-level register bank with axi4-lite access and decoded levels
// How it works
// - debug sources map codes to levels 1-3
// - peripheral sources map codes to levels 0-2
// - every field resets to disabled
// - reserved bits read zero, ignore writes
// - bank 1 holds debug tx, trace
// - bank 2 top holds three flash fields
// - bank 2 holds pll, low voltage
// - bank 2 low holds pin b, a
// - bank 3 top holds ports d, e, f
// - bank 3 holds four can fields
// - bank 4 top holds three serial fields
// - bank 4 low holds ports a, b, c
// - bank 5 holds decoder, async, serial fields
//
// Register access over AXI4-Lite was decided locally.
`default_nettype none
module iplr_top #(
  parameter int ADDR_W = iplr_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            reset,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]               s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // decoded levels to the arbiter, one entry per source
  output logic [iplr_pkg::NUM_SRC-1:0]         src_enable,
  output logic [2*iplr_pkg::NUM_SRC-1:0]       src_level
);
  // stored registers
  logic [15:0] priority_levels_debug_unit;
  logic [15:0] priority_levels_flash_pll_pins;
  logic [15:0] priority_levels_ports_can;
  logic [15:0] priority_levels_spi_ports;
  logic [15:0] priority_levels_decoder_sci;
  // bus side
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [15:0]       wr_data;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [15:0]       rd_data;
  logic              rd_ok;
  // packed field list for the decoders
  logic [2*iplr_pkg::NUM_SRC-1:0] fields;

  // byte address to register index check
  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    hits = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // mask lookup for a byte address; zero means unmapped
  function automatic logic [15:0] mask_of(input logic [ADDR_W-1:0] a);
    mask_of = 16'h0000;
    if (hits(a, iplr_pkg::IDX_DEBUG_UNIT))     mask_of = iplr_pkg::MASK_DEBUG_UNIT;
    if (hits(a, iplr_pkg::IDX_FLASH_PLL_PINS)) mask_of = iplr_pkg::MASK_FLASH_PLL_PINS;
    if (hits(a, iplr_pkg::IDX_PORTS_CAN))      mask_of = iplr_pkg::MASK_PORTS_CAN;
    if (hits(a, iplr_pkg::IDX_SPI_PORTS))      mask_of = iplr_pkg::MASK_SPI_PORTS;
    if (hits(a, iplr_pkg::IDX_DECODER_SCI))    mask_of = iplr_pkg::MASK_DECODER_SCI;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (mask_of(a) != 16'h0000);
  endfunction

  // bus slave
  iplr_axi_slave #(.ADDR_W(ADDR_W)) u_bus (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // write stored to any mapped word; both low byte lanes needed only for an okay response
  logic wr_commit;  // a mapped word lands this cycle
  assign wr_ok     = mapped(wr_addr);
  // lane check only shapes the slave response; a partial word still stores
  assign wr_commit = wr_en && wr_ok;

  // register updates; reserved bits masked off
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      priority_levels_debug_unit     <= iplr_pkg::REG_RESET;
      priority_levels_flash_pll_pins <= iplr_pkg::REG_RESET;
      priority_levels_ports_can      <= iplr_pkg::REG_RESET;
      priority_levels_spi_ports      <= iplr_pkg::REG_RESET;
      priority_levels_decoder_sci    <= iplr_pkg::REG_RESET;
    end else if (wr_commit) begin
      if (hits(wr_addr, iplr_pkg::IDX_DEBUG_UNIT))
        priority_levels_debug_unit <= wr_data & iplr_pkg::MASK_DEBUG_UNIT;
      if (hits(wr_addr, iplr_pkg::IDX_FLASH_PLL_PINS))
        priority_levels_flash_pll_pins <= wr_data & iplr_pkg::MASK_FLASH_PLL_PINS;
      if (hits(wr_addr, iplr_pkg::IDX_PORTS_CAN))
        priority_levels_ports_can <= wr_data & iplr_pkg::MASK_PORTS_CAN;
      if (hits(wr_addr, iplr_pkg::IDX_SPI_PORTS))
        priority_levels_spi_ports <= wr_data & iplr_pkg::MASK_SPI_PORTS;
      if (hits(wr_addr, iplr_pkg::IDX_DECODER_SCI))
        priority_levels_decoder_sci <= wr_data & iplr_pkg::MASK_DECODER_SCI;
    end
  end

  // read mux; unmapped reads zero with error
  always_comb begin
    rd_ok   = mapped(rd_addr);
    rd_data = 16'h0000;
    if (hits(rd_addr, iplr_pkg::IDX_DEBUG_UNIT))     rd_data = priority_levels_debug_unit;
    if (hits(rd_addr, iplr_pkg::IDX_FLASH_PLL_PINS)) rd_data = priority_levels_flash_pll_pins;
    if (hits(rd_addr, iplr_pkg::IDX_PORTS_CAN))      rd_data = priority_levels_ports_can;
    if (hits(rd_addr, iplr_pkg::IDX_SPI_PORTS))      rd_data = priority_levels_spi_ports;
    if (hits(rd_addr, iplr_pkg::IDX_DECODER_SCI))    rd_data = priority_levels_decoder_sci;
  end

  // field gathering in source order 0..28; slots 29..34 held zero
  always_comb begin
    fields[1:0]   = priority_levels_debug_unit[3:2];
    fields[3:2]   = priority_levels_debug_unit[1:0];
    fields[5:4]   = priority_levels_flash_pll_pins[15:14];
    fields[7:6]   = priority_levels_flash_pll_pins[13:12];
    fields[9:8]   = priority_levels_flash_pll_pins[11:10];
    fields[11:10] = priority_levels_flash_pll_pins[9:8];
    fields[13:12] = priority_levels_flash_pll_pins[7:6];
    fields[15:14] = priority_levels_flash_pll_pins[3:2];
    fields[17:16] = priority_levels_flash_pll_pins[1:0];
    fields[19:18] = priority_levels_ports_can[15:14];
    fields[21:20] = priority_levels_ports_can[13:12];
    fields[23:22] = priority_levels_ports_can[11:10];
    fields[25:24] = priority_levels_ports_can[9:8];
    fields[27:26] = priority_levels_ports_can[7:6];
    fields[29:28] = priority_levels_ports_can[5:4];
    fields[31:30] = priority_levels_ports_can[3:2];
    fields[33:32] = priority_levels_spi_ports[15:14];
    fields[35:34] = priority_levels_spi_ports[13:12];
    fields[37:36] = priority_levels_spi_ports[11:10];
    fields[39:38] = priority_levels_spi_ports[5:4];
    fields[41:40] = priority_levels_spi_ports[3:2];
    fields[43:42] = priority_levels_spi_ports[1:0];
    fields[45:44] = priority_levels_decoder_sci[15:14];
    fields[47:46] = priority_levels_decoder_sci[13:12];
    fields[49:48] = priority_levels_decoder_sci[11:10];
    fields[51:50] = priority_levels_decoder_sci[9:8];
    fields[53:52] = priority_levels_decoder_sci[5:4];
    fields[55:54] = priority_levels_decoder_sci[3:2];
    fields[57:56] = priority_levels_decoder_sci[1:0];
    fields[69:58] = '0;
  end

  // per-source decoders; first two are debug sources
  for (genvar i = 0; i < 29; i++) begin : g_dec
    iplr_decode #(.DEBUG_SRC(i < 2)) u_dec (
      .field  (fields[2*i +: 2]),
      .enable (src_enable[i]),
      .level  (src_level[2*i +: 2])
    );
  end
  // unused source slots stay disabled
  assign src_enable[iplr_pkg::NUM_SRC-1:29] = '0;
  assign src_level[2*iplr_pkg::NUM_SRC-1:58] = '0;

  property p_reset_clear;
    @(posedge ref_clk) reset |=> (src_enable == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared by reset");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (reset)
      (priority_levels_flash_pll_pins[5:4] == 2'h0) && (priority_levels_ports_can[1:0] == 2'h0) &&
      (priority_levels_spi_ports[9:6] == 4'h0) && (priority_levels_decoder_sci[7:6] == 2'h0) &&
      (priority_levels_debug_unit[15:4] == 12'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_write_effect;
    @(posedge ref_clk) disable iff (reset)
      (wr_commit && hits(wr_addr, iplr_pkg::IDX_DEBUG_UNIT))
        |=> (priority_levels_debug_unit == ($past(wr_data) & iplr_pkg::MASK_DEBUG_UNIT));
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("write not applied next cycle");

  property p_debug_map;
    @(posedge ref_clk) disable iff (reset)
      src_enable[1] |-> (src_level[3:2] == priority_levels_debug_unit[1:0]);
  endproperty
  a_debug_map: assert property (p_debug_map) else $error("debug level mismatch");

  property p_periph_map;
    @(posedge ref_clk) disable iff (reset)
      src_enable[8] |-> (src_level[17:16] == priority_levels_flash_pll_pins[1:0] - 2'h1);
  endproperty
  a_periph_map: assert property (p_periph_map) else $error("peripheral level mismatch");

  property p_can_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[15] == (priority_levels_ports_can[3:2] != 2'h0);
  endproperty
  a_can_place: assert property (p_can_place) else $error("can field misplaced");

  property p_dec_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[28] == (priority_levels_decoder_sci[1:0] != 2'h0);
  endproperty
  a_dec_place: assert property (p_dec_place) else $error("serial0 tx field misplaced");

  property p_port_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[21] == (priority_levels_spi_ports[1:0] != 2'h0);
  endproperty
  a_port_place: assert property (p_port_place) else $error("port c field misplaced");

  property p_debug_tx_level;
    @(posedge ref_clk) disable iff (reset)
      src_enable[0] |-> (src_level[1:0] == priority_levels_debug_unit[3:2]);
  endproperty
  a_debug_tx_level: assert property (p_debug_tx_level) else $error("debug tx level misplaced");

  property p_flash_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[4] == (priority_levels_flash_pll_pins[11:10] != 2'h0);
  endproperty
  a_flash_place: assert property (p_flash_place) else $error("flash error field misplaced");

  property p_low_voltage_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[6] == (priority_levels_flash_pll_pins[7:6] != 2'h0);
  endproperty
  a_low_voltage_place: assert property (p_low_voltage_place) else $error("low voltage field misplaced");

  property p_pin_b_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[7] == (priority_levels_flash_pll_pins[3:2] != 2'h0);
  endproperty
  a_pin_b_place: assert property (p_pin_b_place) else $error("pin b field misplaced");

  property p_port_f_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[11] == (priority_levels_ports_can[11:10] != 2'h0);
  endproperty
  a_port_f_place: assert property (p_port_f_place) else $error("port f field misplaced");

  property p_serial_place;
    @(posedge ref_clk) disable iff (reset)
      src_enable[18] == (priority_levels_spi_ports[11:10] != 2'h0);
  endproperty
  a_serial_place: assert property (p_serial_place) else $error("serial1 rx field misplaced");
endmodule
`default_nettype wire

// *** test/iplr_core_model.sv ***
// iplr_core_model: core-side arbiter that picks the highest enabled requesting level
`default_nettype none
module iplr_core_model (
  // decoded levels from the bank
  input  wire logic [iplr_pkg::NUM_SRC-1:0]   src_enable,
  input  wire logic [2*iplr_pkg::NUM_SRC-1:0] src_level,
  // raw request lines from the peripherals
  input  wire logic [iplr_pkg::NUM_SRC-1:0]   src_req,
  // winning request towards the core
  output logic                                req_valid,
  output logic [1:0]                          req_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // a disabled source never competes, even while it requests
  always_comb begin
    req_valid = 1'b0;
    req_level = 2'h0;
    for (int i = 0; i < iplr_pkg::NUM_SRC; i++) begin
      if (src_req[i] && src_enable[i] && (!req_valid || src_level[2*i+:2] > req_level)) begin
        req_valid = 1'b1;
        req_level = src_level[2*i+:2];
      end
    end
  end
endmodule
`default_nettype wire

// *** test/iplr_top_tb.sv ***
// iplr_top_tb: self-checking bench for the priority-level register bank
`default_nettype none
module iplr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NS = iplr_pkg::NUM_SRC;
  // clock, reset and bus drive
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [NS-1:0]     src_req = '0;
  // design and partner outputs
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, req_level;
  logic [31:0]       s_axi_rdata;
  logic [NS-1:0]     src_enable;
  logic [2*NS-1:0]   src_level;
  logic              req_valid;
  // field table: register index and lsb of each source
  int                reg_tab[29] = '{1,1,2,2,2,2,2,2,2,3,3,3,3,3,3,3,4,4,4,4,4,4,5,5,5,5,5,5,5};
  int                lsb_tab[29] = '{2,0,14,12,10,8,6,2,0,14,12,10,8,6,4,2,14,12,10,4,2,0,14,12,10,8,4,2,0};
  logic [15:0]       mask[1:5];
  logic [15:0]       mdl[1:5];
  logic [31:0]       rng = 32'd51;
  int                errors = 0, compares = 0, cycles = 0;

  iplr_top #(.ADDR_W(8)) iplr_top_inst (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_enable(src_enable), .src_level(src_level));

  iplr_core_model iplr_core_model_inst (
    .src_enable(src_enable), .src_level(src_level), .src_req(src_req),
    .req_valid(req_valid), .req_level(req_level));

  // 10 mhz clock
  always #50 ref_clk = ~ref_clk;

  // watchdog against a hung handshake
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end

  // xorshift source for stimulus
  function logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input string name, input logic [2*NS-1:0] exp, input logic [2*NS-1:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    bit ta, tw, tb;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(negedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) ta = 1;
      if (s_axi_wvalid && s_axi_wready) tw = 1;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge ref_clk);
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask

  // one read: address held until taken, data taken with rvalid
  task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
    bit t;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      t = s_axi_arvalid && s_axi_arready;
      @(posedge ref_clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge ref_clk);
      t = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask

  // decoded outputs against the model, then one arbitration through the partner
  task automatic check_levels();
    logic [NS-1:0] en;
    logic [2*NS-1:0] lv;
    logic [1:0] c, el;
    logic [63:0] r;
    bit ev;
    en = '0;
    lv = '0;
    for (int i = 0; i < 29; i++) begin
      c = mdl[reg_tab[i]][lsb_tab[i]+:2];
      if (c != 2'h0) begin
        en[i] = 1'b1;
        lv[2*i+:2] = (i < 2) ? c : c - 2'h1;
      end
    end
    @(negedge ref_clk);
    check("src_enable", {{NS{1'b0}}, en}, {{NS{1'b0}}, src_enable});
    check("src_level", lv, src_level);
    @(posedge ref_clk);
    r = {next_rand(), next_rand()};
    src_req <= r[NS-1:0];
    ev = 0;
    el = 2'h0;
    for (int i = 0; i < NS; i++)
      if (r[i] && en[i] && (!ev || lv[2*i+:2] > el)) begin
        ev = 1;
        el = lv[2*i+:2];
      end
    @(negedge ref_clk);
    check("arbitration", {67'h0, ev, el}, {67'h0, req_valid, req_level});
  endtask

  // write, check response and outputs, read back
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] resp;
    logic [31:0] rd;
    bit mapped;
    int k;
    k = int'(a[7:2]);
    mapped = (a[1:0] == 2'h0) && k >= 1 && k <= 5;
    axi_write(a, d, resp);
    if (mapped) mdl[k] = d & mask[k];
    check("bresp", mapped ? iplr_pkg::RESP_OKAY : iplr_pkg::RESP_SLVERR, resp);
    check_levels();
    axi_read(a, rd, resp);
    check("rdata", mapped ? {16'h0, mdl[k]} : 32'h0, rd);
    check("rresp", mapped ? iplr_pkg::RESP_OKAY : iplr_pkg::RESP_SLVERR, resp);
  endtask

  task automatic complete_run();
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] rd, r;
    logic [1:0]  rr;
    for (int k = 1; k <= 5; k++) begin
      mask[k] = 16'h0;
      mdl[k] = 16'h0;
    end
    for (int i = 0; i < 29; i++) mask[reg_tab[i]] |= 16'h3 << lsb_tab[i];
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // reset values
    check_levels();
    for (int k = 1; k <= 5; k++) begin
      axi_read(8'(4 * k), rd, rr);
      check("reset value", 0, rd);
      check("reset rresp", iplr_pkg::RESP_OKAY, rr);
    end
    // every code in every field, including reserved bits set
    for (int k = 1; k <= 5; k++)
      for (int c = 0; c < 4; c++) wr_rd(8'(4 * k), {8{2'(c)}});
    // unmapped places refuse
    wr_rd(8'h00, 16'hffff);
    wr_rd(8'h18, 16'hffff);
    wr_rd(8'hfc, 16'h5555);
    // random traffic to mapped registers, each write checked and read back
    repeat (30) begin
      r = next_rand();
      wr_rd(8'((r[7:0] % 5 + 1) * 4), r[31:16]);
    end
    // second reset clears every field
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    for (int k = 1; k <= 5; k++) mdl[k] = 16'h0;
    check_levels();
    complete_run();
  end
endmodule
`default_nettype wire
